// ==== logic/mem_pin_pkg.sv ====
`default_nettype none

package mem_pin_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;          // 50 MHz
  // least time to whole cycles, never below one
  function automatic int unsigned min_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction
  localparam int unsigned T_RCD_NS       = 20;         // activate to column
  localparam int unsigned T_RP_NS        = 20;         // precharge period
  localparam int unsigned T_TAIL_NS      = 40;         // read latency / recovery
  localparam int unsigned T_RCD_CYC      = min_cycles(T_RCD_NS);
  localparam int unsigned T_RP_CYC       = min_cycles(T_RP_NS);
  localparam int unsigned T_TAIL_CYC     = min_cycles(T_TAIL_NS);
  localparam int unsigned CS_TIMEOUT     = 64;         // cycles without ack
  localparam int unsigned TMR_W          = 8;

  // ----------------------------------------------------------------
  // widths and layouts
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W         = 11;         // row / column width
  localparam int unsigned A10_POS        = 10;         // dedicated bit
  localparam int unsigned LANES          = 4;
  localparam int unsigned PROG_LINES     = 6;
  localparam int unsigned PROG_DEPTH     = 16;
  localparam int unsigned PROG_IDX_W     = $clog2(PROG_DEPTH);
  localparam logic [PROG_LINES-1:0] PROG_LINES_IDLE = 6'h3F;
  localparam int unsigned SYNC_STAGES    = 2;

  typedef enum logic [1:0] {
    MACH_SDRAM,
    MACH_CHIPSEL,
    MACH_PROG
  } machine_t;

  // one access request from the internal bus side
  typedef struct packed {
    machine_t                mach;
    logic                    write;
    logic                    precharge_only;  // sdram: precharge alone
    logic                    all_banks;       // sdram: precharge scope
    logic [ADDR_W-1:0]       row;
    logic [ADDR_W-1:0]       col;
    logic [LANES-1:0]        byte_en;
    logic [PROG_IDX_W-1:0]   pattern_start;
  } mem_req_t;

  // one word of the programmable machine pattern
  typedef struct packed {
    logic [PROG_LINES-1:0]   lines;
    logic                    wait_check;      // stall here while wait low
    logic                    last;            // final word of the pattern
  } prog_word_t;

  // completion report
  typedef struct packed {
    logic                    done;
    logic                    acked;           // chip select ended by ack
    logic                    timeout;         // chip select timed out
  } mem_status_t;

endpackage

`default_nettype wire

// ==== logic/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser for active-low pins, idles high
module pin_sync
  import mem_pin_pkg::*;
#(
  parameter int unsigned W = 2
)(
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  // pins and synchronised levels
  input  wire logic [W-1:0] i_pin_n,
  output logic      [W-1:0] o_sync_n
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // first stage is read only by the second
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      meta_r <= '1;
      sync_r <= '1;
    end
    else
    begin
      meta_r <= i_pin_n;
      sync_r <= meta_r;
    end
  end

  assign o_sync_n = sync_r;

endmodule
`default_nettype wire

// ==== logic/prog_machine_seq.sv ====
`timescale 1ns/1ps
`default_nettype none

// pattern runner for the programmable machine
module prog_machine_seq
  import mem_pin_pkg::*;
#(
  parameter int unsigned DEPTH = PROG_DEPTH
)(
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  // pattern load
  input  wire logic                  i_wr_en,
  input  wire logic [PROG_IDX_W-1:0] i_wr_addr,
  input  wire prog_word_t            i_wr_word,
  // run control
  input  wire logic                  i_start,
  input  wire logic [PROG_IDX_W-1:0] i_start_idx,
  input  wire logic                  i_wait_n,
  // results
  output logic [PROG_LINES-1:0]      o_lines,
  output logic                       o_busy,
  output logic                       o_done
);

  prog_word_t            mem [DEPTH];
  logic [PROG_IDX_W-1:0] idx_r;
  logic                  busy_r;
  logic                  done_r;
  logic [PROG_LINES-1:0] lines_r;
  prog_word_t            cur;

  assign cur = mem[idx_r];

  // pattern storage has no reset; software loads it before use
  always_ff @(posedge i_clk)
  begin
    if (i_wr_en)
      mem[i_wr_addr] <= i_wr_word;
  end

  // step through the pattern, holding on a wait-checked word
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      idx_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (!busy_r)
      begin
        if (i_start)
        begin
          idx_r  <= i_start_idx;
          busy_r <= 1'b1;
        end
      end
      else if (cur.wait_check && !i_wait_n)
        idx_r <= idx_r;                     // stalled by device
      else if (cur.last)
      begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end
      else
        idx_r <= idx_r + 1'b1;
    end
  end

  // lines follow the current word only; idle level otherwise
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      lines_r <= PROG_LINES_IDLE;
    else if (busy_r)
      lines_r <= cur.lines;
    else
      lines_r <= PROG_LINES_IDLE;
  end

  assign o_lines = lines_r;
  assign o_busy  = busy_r;
  assign o_done  = done_r;

endmodule
`default_nettype wire

// ==== logic/memory_pin_control.sv ====
// Operation
// - on precharge, the a10 pin selects one bank or all banks
// - during the row phase, the a10 pin carries a row address bit
// - during the column phase, the a10 pin carries a column address bit
// - separate row strobe, column strobe and write strobe to the sdram
// - six programmable lines follow the pattern software loaded
// - wait held low by the device stalls the programmable machine
// - chip-select access ends when the device asserts transfer ack
// - output enable switches memory output buffers on during chip-select reads
// - parity byte select drives the separate parity chip
// - in external master mode, a mux control steers row versus column
// - four byte masks, one per lane, select sdram byte lanes
`timescale 1ns/1ps
`default_nettype none

module memory_pin_control
  import mem_pin_pkg::*;
(
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  // access request from the internal bus
  input  wire logic                  i_req_valid,
  input  wire mem_req_t              i_req,
  output logic                       o_req_ready,
  output mem_status_t                o_status,
  // configuration levels
  input  wire logic                  i_ext_master_mode,
  input  wire logic                  i_parity_en,
  // programmable machine pattern load
  input  wire logic                  i_pat_wr_en,
  input  wire logic [PROG_IDX_W-1:0] i_pat_wr_addr,
  input  wire prog_word_t            i_pat_wr_word,
  // sdram pins
  output logic                       o_sdram_row_strobe_n,
  output logic                       o_sdram_column_strobe_n,
  output logic                       o_sdram_write_strobe_n,
  output logic                       o_sdram_precharge_address_bit,
  output logic [ADDR_W-2:0]          o_sdram_addr,
  output logic [LANES-1:0]           o_sdram_byte_mask,
  output logic                       o_sdram_address_mux_ctrl,
  // chip-select machine pins
  output logic                       o_chip_select_n,
  output logic                       o_memory_output_enable_n,
  input  wire logic                  i_chip_select_transfer_ack_n,
  // programmable machine pins
  output logic [PROG_LINES-1:0]      o_prog_machine_line,
  input  wire logic                  i_prog_machine_wait_in_n,
  // parity chip
  output logic                       o_parity_byte_select_n
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pins_sync_n;
  logic       ta_n;
  logic       wait_n;

  // both pins come from outside the clock domain
  pin_sync #(
    .W        (2)
  ) u_sync (
    .i_clk    (i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin_n  ({i_chip_select_transfer_ack_n, i_prog_machine_wait_in_n}),
    .o_sync_n (pins_sync_n)
  );

  assign ta_n   = pins_sync_n[1];
  assign wait_n = pins_sync_n[0];

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SD_ACT,
    ST_SD_RCD,
    ST_SD_TAIL,
    ST_SD_PRE,
    ST_SD_RP,
    ST_CHIPSEL,
    ST_PROG
  } state_t;

  state_t           state_r;
  state_t           state_nxt;
  mem_req_t         req_r;
  logic [TMR_W-1:0] tmr_r;
  logic             tmr_zero;
  logic             take;
  logic             prog_start;
  logic             prog_done;

  assign take        = i_req_valid && (state_r == ST_IDLE);
  assign o_req_ready = (state_r == ST_IDLE);
  assign tmr_zero    = (tmr_r == '0);
  assign prog_start  = take && (i_req.mach == MACH_PROG);

  // next state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
        if (take)
        begin
          unique case (i_req.mach)
            MACH_CHIPSEL: state_nxt = ST_CHIPSEL;
            MACH_PROG:    state_nxt = ST_PROG;
            default:      state_nxt = i_req.precharge_only ? ST_SD_PRE
                                                           : ST_SD_ACT;
          endcase
        end
      ST_SD_ACT:  state_nxt = ST_SD_RCD;
      ST_SD_RCD:  if (tmr_zero) state_nxt = ST_SD_TAIL;
      ST_SD_TAIL: if (tmr_zero) state_nxt = ST_IDLE;
      ST_SD_PRE:  state_nxt = ST_SD_RP;
      ST_SD_RP:   if (tmr_zero) state_nxt = ST_IDLE;
      ST_CHIPSEL: if (!ta_n || tmr_zero) state_nxt = ST_IDLE;
      ST_PROG:    if (prog_done) state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // request captured at acceptance and held through the access
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      req_r <= '0;
    else if (take)
      req_r <= i_req;
  end

  // ----------------------------------------------------------------
  // wait timer, reloaded on each timed phase
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      tmr_r <= '0;
    else if (take && i_req.mach == MACH_CHIPSEL)
      tmr_r <= TMR_W'(CS_TIMEOUT - 1);
    else if (state_r == ST_SD_ACT)
      tmr_r <= TMR_W'(T_RCD_CYC - 1);
    else if (state_r == ST_SD_RCD && tmr_zero)
      tmr_r <= TMR_W'(T_TAIL_CYC - 1);
    else if (state_r == ST_SD_PRE)
      tmr_r <= TMR_W'(T_RP_CYC - 1);
    else if (!tmr_zero)
      tmr_r <= tmr_r - 1'b1;
  end

  // ----------------------------------------------------------------
  // sdram command pins
  // ----------------------------------------------------------------
  logic             ras_nxt;
  logic             cas_nxt;
  logic             we_nxt;
  logic             a10_nxt;
  logic [ADDR_W-2:0] addr_nxt;
  logic [LANES-1:0] dqm_nxt;
  logic             row_phase;

  // command decode: nop unless a command cycle is entered
  always_comb
  begin
    ras_nxt   = 1'b1;
    cas_nxt   = 1'b1;
    we_nxt    = 1'b1;
    a10_nxt   = 1'b0;
    addr_nxt  = '0;
    dqm_nxt   = '1;
    row_phase = 1'b0;
    if (state_nxt == ST_SD_ACT)
    begin
      ras_nxt   = 1'b0;                           // activate
      a10_nxt   = i_req.row[A10_POS];
      addr_nxt  = i_req.row[ADDR_W-2:0];
      row_phase = 1'b1;
    end
    else if (state_r == ST_SD_RCD && tmr_zero)
    begin
      cas_nxt   = 1'b0;                           // read or write
      we_nxt    = !req_r.write;
      a10_nxt   = req_r.col[A10_POS];
      addr_nxt  = req_r.col[ADDR_W-2:0];
      dqm_nxt   = ~req_r.byte_en;
    end
    else if (state_nxt == ST_SD_PRE)
    begin
      ras_nxt   = 1'b0;                           // precharge
      we_nxt    = 1'b0;
      a10_nxt   = i_req.all_banks;
      addr_nxt  = i_req.row[ADDR_W-2:0];
    end
  end

  // strobes leave from flops for clean pin timing
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_sdram_row_strobe_n          <= 1'b1;
      o_sdram_column_strobe_n       <= 1'b1;
      o_sdram_write_strobe_n        <= 1'b1;
      o_sdram_precharge_address_bit <= 1'b0;
      o_sdram_addr                  <= '0;
      o_sdram_byte_mask             <= '1;
    end
    else
    begin
      o_sdram_row_strobe_n          <= ras_nxt;
      o_sdram_column_strobe_n       <= cas_nxt;
      o_sdram_write_strobe_n        <= we_nxt;
      o_sdram_precharge_address_bit <= a10_nxt;
      o_sdram_addr                  <= addr_nxt;
      o_sdram_byte_mask             <= dqm_nxt;
    end
  end

  // external mux: high selects row, only meaningful in external master mode
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_sdram_address_mux_ctrl <= 1'b0;
    else
      o_sdram_address_mux_ctrl <= i_ext_master_mode && row_phase;
  end

  // ----------------------------------------------------------------
  // chip-select machine pins
  // ----------------------------------------------------------------
  logic chipsel_on;

  assign chipsel_on = (state_nxt == ST_CHIPSEL);

  // ack ends the access one cycle after it is seen low
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_chip_select_n          <= 1'b1;
      o_memory_output_enable_n <= 1'b1;
    end
    else
    begin
      o_chip_select_n          <= !chipsel_on;
      o_memory_output_enable_n <= !(chipsel_on && !(take ? i_req.write
                                                      : req_r.write));
    end
  end

  // ----------------------------------------------------------------
  // programmable machine
  // ----------------------------------------------------------------
  prog_machine_seq #(
    .DEPTH       (PROG_DEPTH)
  ) u_prog (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_wr_en     (i_pat_wr_en),
    .i_wr_addr   (i_pat_wr_addr),
    .i_wr_word   (i_pat_wr_word),
    .i_start     (prog_start),
    .i_start_idx (i_req.pattern_start),
    .i_wait_n    (wait_n),
    .o_lines     (o_prog_machine_line),
    .o_busy      (),
    .o_done      (prog_done)
  );

  // ----------------------------------------------------------------
  // parity byte select and completion report
  // ----------------------------------------------------------------
  // parity chip joins chip-select and programmable accesses alike
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_parity_byte_select_n <= 1'b1;
    else
      o_parity_byte_select_n <= !(i_parity_en &&
                                  (chipsel_on || state_nxt == ST_PROG));
  end

  // one-cycle done pulse with the cause of a chip-select finish
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_status <= '0;
    else
    begin
      o_status.done    <= (state_r != ST_IDLE) && (state_nxt == ST_IDLE);
      o_status.acked   <= (state_r == ST_CHIPSEL) && !ta_n;
      o_status.timeout <= (state_r == ST_CHIPSEL) && ta_n && tmr_zero;
    end
  end

endmodule
`default_nettype wire

// ==== dv/mem_pin_sva.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// pin relations of the memory controller
// ----------------------------------------
module mem_pin_sva
  import mem_pin_pkg::*;
(
  // clock, reset and request side
  input wire logic              i_clk,
  input wire logic              i_sys_rst,
  input wire logic              i_req_valid,
  input wire mem_req_t          i_req,
  input wire logic              o_req_ready,
  input wire mem_status_t       o_status,
  input wire logic              i_ext_master_mode,
  input wire logic              i_parity_en,
  // pins
  input wire logic              o_sdram_row_strobe_n,
  input wire logic              o_sdram_column_strobe_n,
  input wire logic              o_sdram_write_strobe_n,
  input wire logic              o_sdram_precharge_address_bit,
  input wire logic [ADDR_W-2:0] o_sdram_addr,
  input wire logic [LANES-1:0]  o_sdram_byte_mask,
  input wire logic              o_sdram_address_mux_ctrl,
  input wire logic              o_chip_select_n,
  input wire logic              o_memory_output_enable_n,
  input wire logic              i_chip_select_transfer_ack_n,
  input wire logic              o_parity_byte_select_n
);
  wire logic take = i_req_valid && o_req_ready;
  wire logic ras  = o_sdram_row_strobe_n;
  wire logic cas  = o_sdram_column_strobe_n;
  wire logic we   = o_sdram_write_strobe_n;
  wire logic a10  = o_sdram_precharge_address_bit;
  wire logic cs   = o_chip_select_n;
  mem_req_t  q_r;

  // copy of the request, since command cycles come after the take
  always_ff @(posedge i_clk)
    if (take)
      q_r <= i_req;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // sdram access, lone precharge, acknowledge seen twice in a select
  sequence s_act;
    take && i_req.mach == MACH_SDRAM && !i_req.precharge_only;
  endsequence
  sequence s_pre;
    take && i_req.mach == MACH_SDRAM && i_req.precharge_only;
  endsequence
  sequence s_ack;
    (!cs && !i_chip_select_transfer_ack_n) [*2];
  endsequence

  a_pre_scope: assert property (
    s_pre |=> !ras && !we && cas && a10 == q_r.all_banks)
    else $error("precharge scope wrong");
  a_act_row: assert property (
    s_act |=> !ras && cas && we && a10 == q_r.row[A10_POS]
      && o_sdram_addr == q_r.row[ADDR_W-2:0])
    else $error("row phase wrong");
  a_col_phase: assert property (
    s_act |-> ##3 (!cas && ras && we == !q_r.write
      && a10 == q_r.col[A10_POS] && o_sdram_byte_mask == ~q_r.byte_en))
    else $error("column phase wrong");
  a_cmd_pulse: assert property (
    (!ras || !cas) |=> ras && cas)
    else $error("strobe longer than one cycle");
  a_mask_idle: assert property (
    cas |-> o_sdram_byte_mask == 4'hF)
    else $error("lanes open outside column cycle");
  a_mux_row: assert property (
    s_act |=> o_sdram_address_mux_ctrl == $past(i_ext_master_mode))
    else $error("mux control wrong at activate");
  a_mux_only: assert property (
    o_sdram_address_mux_ctrl |-> !ras && i_ext_master_mode)
    else $error("mux control outside activate");
  a_read_oe: assert property (
    take && i_req.mach == MACH_CHIPSEL |=> !cs
      && o_memory_output_enable_n == q_r.write)
    else $error("output enable wrong");
  a_ack_ends: assert property (
    s_ack |-> ##[0:2] (o_status.done && o_status.acked))
    else $error("ack did not end access");
  a_parity_sel: assert property (
    !cs |-> o_parity_byte_select_n == !i_parity_en)
    else $error("parity select wrong");
endmodule

bind memory_pin_control mem_pin_sva u_sva (.*);

`default_nettype wire

// ==== dv/mem_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// far side: acking peripheral, slow device
// ----------------------------------------
module mem_far_model
  import mem_pin_pkg::*;
(
  // clock and pins watched
  input  wire logic                  i_clk,
  input  wire logic                  i_cs_n,
  input  wire logic [PROG_LINES-1:0] i_lines,
  // knobs from the bench
  input  wire logic [3:0]            i_ack_dly,
  input  wire logic                  i_ack_off,
  input  wire logic [3:0]            i_wait_len,
  // answers
  output logic                       o_ack_n,
  output logic                       o_wait_n
);
  logic [3:0]            cs_cnt_r = '0;
  logic [3:0]            wt_cnt_r = '0;
  logic [PROG_LINES-1:0] prev_r   = PROG_LINES_IDLE;

  initial o_ack_n = 1'b1;

  // ack low a set time into the select; the pull-up lifts it on the edge
  // after the select ends, so no stale low leaks into the next access
  always @(posedge i_clk)
  begin
    cs_cnt_r <= i_cs_n ? 4'h0 : cs_cnt_r + 4'h1;
    if (i_cs_n)
      o_ack_n <= 1'b1;
    else if (!i_ack_off && cs_cnt_r == i_ack_dly)
      o_ack_n <= 1'b0;
  end

  // not ready for a while once a pattern starts on the lines
  always @(posedge i_clk)
  begin
    prev_r <= i_lines;
    if (prev_r == PROG_LINES_IDLE && i_lines != PROG_LINES_IDLE)
      wt_cnt_r <= i_wait_len;
    else if (wt_cnt_r != 4'h0)
      wt_cnt_r <= wt_cnt_r - 4'h1;
  end
  assign o_wait_n = (wt_cnt_r == 4'h0);
endmodule

`default_nettype wire

// ==== dv/memory_pin_control_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module memory_pin_control_tb_top
  import mem_pin_pkg::*;
;
  // ----------------------------------------
  // stimulus, pins and bench state
  // ----------------------------------------
  logic                  i_clk = 1'b0;
  logic                  i_sys_rst = 1'b1;
  logic                  i_req_valid = 1'b0;
  mem_req_t              i_req = '0;
  logic                  i_ext_master_mode = 1'b0;
  logic                  i_parity_en = 1'b0;
  logic                  i_pat_wr_en = 1'b0;
  logic [PROG_IDX_W-1:0] i_pat_wr_addr = '0;
  prog_word_t            i_pat_wr_word = '0;
  logic                  o_req_ready;
  mem_status_t           o_status;
  logic                  o_sdram_row_strobe_n;
  logic                  o_sdram_column_strobe_n;
  logic                  o_sdram_write_strobe_n;
  logic                  o_sdram_precharge_address_bit;
  logic [ADDR_W-2:0]     o_sdram_addr;
  logic [LANES-1:0]      o_sdram_byte_mask;
  logic                  o_sdram_address_mux_ctrl;
  logic                  o_chip_select_n;
  logic                  o_memory_output_enable_n;
  logic                  i_chip_select_transfer_ack_n;
  logic [PROG_LINES-1:0] o_prog_machine_line;
  logic                  i_prog_machine_wait_in_n;
  logic                  o_parity_byte_select_n;
  logic [3:0]            ack_dly = '0;
  logic                  ack_off = 1'b0;
  logic [3:0]            wait_len = '0;
  int                    fails = 0;
  int                    checks_done = 0;
  int                    seed = 32'h7FEABDFD;
  int                    n;
  int                    wcnt;
  int                    st;
  mem_req_t              r;
  mem_req_t              cur = '0;
  mem_status_t           res;
  logic [31:0]           rnd;
  logic [5:0]            seen[$];
  wire logic             a10 = o_sdram_precharge_address_bit;

  memory_pin_control u_dut (.*);
  mem_far_model u_far (
    .i_clk      (i_clk),
    .i_cs_n     (o_chip_select_n),
    .i_lines    (o_prog_machine_line),
    .i_ack_dly  (ack_dly),
    .i_ack_off  (ack_off),
    .i_wait_len (wait_len),
    .o_ack_n    (i_chip_select_transfer_ack_n),
    .o_wait_n   (i_prog_machine_wait_in_n)
  );

  always #10 i_clk = ~i_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s: got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  task automatic finish_test();
    if (fails == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // cycles from take to done, worked out from the timing constants
  function automatic int exp_lat(input mem_req_t q);
    return q.precharge_only ? 2 + T_RP_CYC : 2 + T_RCD_CYC + T_TAIL_CYC;
  endfunction

  // present one request for one edge (idle, so taken), count to done;
  // the gap after it lets the far side and the synchronisers settle
  task automatic run(input mem_req_t q);
    @(posedge i_clk);
    i_req_valid <= 1'b1;
    i_req       <= q;
    cur = q;
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge i_clk);
      n++;
    end
    while (o_status.done !== 1'b1 && n < 200);
    res = o_status;
    repeat (10) @(posedge i_clk);
  endtask

  // pin monitor at mid-cycle, where registered pins are settled
  always @(negedge i_clk)
  begin
    if (!i_sys_rst && !o_sdram_column_strobe_n)
    begin
      chk(a10, cur.col[A10_POS], "column bit");
      chk(o_sdram_addr, cur.col[ADDR_W-2:0], "column addr");
      chk(o_sdram_write_strobe_n, !cur.write, "write strobe");
    end
    if (!o_sdram_row_strobe_n && o_sdram_write_strobe_n)
    begin
      chk(a10, cur.row[A10_POS], "row bit");
      chk(o_sdram_address_mux_ctrl, i_ext_master_mode, "mux");
    end
    if (!o_chip_select_n)
    begin
      chk(o_memory_output_enable_n, cur.write, "oe");
      chk(o_parity_byte_select_n, !i_parity_en, "parity");
    end
    if (o_status.done)
      chk(o_req_ready, 1'b1, "ready after done");
    if (o_prog_machine_line != PROG_LINES_IDLE)
    begin
      if (seen.size() == 0 || seen[$] != o_prog_machine_line)
        seen.push_back(o_prog_machine_line);
      if (o_prog_machine_line == 6'((st + 4) * 2))
        wcnt++;
    end
  end

  // watchdog: far beyond the length of all scenarios together
  initial
  begin
    #(CLK_PERIOD_NS * 20000);
    fails++;
    finish_test();
  end

  initial
  begin
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_clk);
    chk({o_sdram_row_strobe_n, o_sdram_column_strobe_n,
         o_sdram_write_strobe_n, o_sdram_byte_mask, o_prog_machine_line},
        {3'h7, 4'hF, PROG_LINES_IDLE}, "reset");
    // sdram: extreme addresses and lanes first, both precharge scopes
    for (int k = 0; k < 16; k++)
    begin
      rnd = $random(seed);
      r = '0;
      r.mach = MACH_SDRAM;
      {r.all_banks, r.write, r.row, r.col, r.byte_en} = rnd[27:0];
      if (k == 0)
        {r.row, r.col, r.byte_en} = '0;
      if (k == 1)
        {r.row, r.col, r.byte_en} = '1;
      r.precharge_only = (k == 2 || k == 3 || rnd[29:28] == 2'h0);
      if (k == 2 || k == 3)
        r.all_banks = k[0];
      @(posedge i_clk);
      i_ext_master_mode <= rnd[30];
      run(r);
      chk(n, exp_lat(r), "sdram latency");
    end
    // chip select: reads and writes acked at random, last one never
    for (int k = 0; k < 6; k++)
    begin
      rnd = $random(seed);
      r = '0;
      r.mach = MACH_CHIPSEL;
      r.write = rnd[0];
      ack_dly <= rnd[4:1];
      ack_off <= (k == 5);
      @(posedge i_clk);
      i_parity_en <= rnd[5];
      run(r);
      chk({res.acked, res.timeout}, {!ack_off, ack_off}, "end");
      chk(ack_off ? n >= CS_TIMEOUT : n == ack_dly + 3 + SYNC_STAGES, 1,
          "end time");
    end
    // patterns 0..5 (wait checked at 4) and 8..13 (never checked)
    for (int k = 0; k < PROG_DEPTH; k++)
    begin
      @(posedge i_clk);
      i_pat_wr_en   <= 1'b1;
      i_pat_wr_addr <= k[PROG_IDX_W-1:0];
      i_pat_wr_word <= {6'(k * 2), k == 4, k == 5 || k == 13};
    end
    @(posedge i_clk);
    i_pat_wr_en <= 1'b0;
    for (int k = 0; k < 6; k++)
    begin
      rnd = $random(seed);
      st = rnd[0] ? 8 : 0;
      wait_len <= k[0] ? 4'h8 : 4'h0;
      seen.delete();
      wcnt = 0;
      r = '0;
      r.mach = MACH_PROG;
      r.pattern_start = st[PROG_IDX_W-1:0];
      run(r);
      chk(seen.size(), 6, "pattern length");
      for (int j = 0; j < 6; j++)
        chk(seen[j], 6'((st + j) * 2), "pattern line");
      chk(wcnt > 1, k[0] && st == 0, "stall");
      chk(res.done, 1'b1, "pattern end");
    end
    finish_test();
  end
endmodule

`default_nettype wire
